// ===== hw/cmc_defs.vh
// Constants for the clock mode configuration block
`ifndef CMC_DEFS_VH
`define CMC_DEFS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CMC_ADDR_W 20
`define CMC_CTRL_ADDR 20'h10c80
`define CMC_MODE_ADDR 20'h10c88

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CMC_CTRL_CLKDIS_BIT 27
`define CMC_CTRL_BAUD_LSB 30
`define CMC_CTRL_BAUD_MSB 31
`define CMC_CTRL_CLKDIS_RST 1'b0
`define CMC_CTRL_BAUD_RST 2'b01

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define CMC_MODE_CPDF_LSB 0
`define CMC_MODE_CMF_LSB 4
`define CMC_MODE_BUS_DIVIDER_LSB 8
`define CMC_MODE_PPDF_LSB 12
`define CMC_MODE_SPDF_LSB 16
`define CMC_MODE_SMF_LSB 20
`define CMC_MODE_DELAY_LOOP_DISABLE_BIT 25
`define CMC_MODE_CORE_DIVIDER_LSB 28

// ----------------------------------------
// Field codes
// ----------------------------------------
`define CMC_CORE_MF_CODE 4'h5
`define CMC_CPDF_MAX 4'h3
`define CMC_BUS_DIVIDER_MIN 4'h1
`define CMC_BUS_DIVIDER_MAX 4'h5
`define CMC_PPDF_MAX 4'h2
`define CMC_SPDF_MAX 4'h5
`define CMC_SMF_MIN 4'h5
`define CMC_CORE_DIVIDER_MAX 4'h5

// ----------------------------------------
// Divider ratios, minus one
// ----------------------------------------
`define CMC_SCC_DIV_M1 8'h03
`define CMC_BAUD_DIV4_M1 8'h03
`define CMC_BAUD_DIV16_M1 8'h0f
`define CMC_BAUD_DIV64_M1 8'h3f
`define CMC_BAUD_DIV256_M1 8'hff

// ----------------------------------------
// Capture timing
// ----------------------------------------
`define CMC_CAPTURE_WAIT 2'h2

`endif

// ===== hw/cmc_clk_div.v
// Programmable divider producing a one-cycle enable pulse
`timescale 1ns/1ps

module cmc_clk_div #(
  parameter W = 8
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire run_in,
  input wire [W-1:0] ratio_m1_in,
  output reg tick_out
);

  reg [W-1:0] count_reg;
  wire wrap;

  // Compare with >= so a smaller ratio never waits out a full counter lap
  assign wrap = (count_reg >= ratio_m1_in);

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= {W{1'b0}};
      tick_out <= 1'b0;
    end else if (run_in) begin
      count_reg <= wrap ? {W{1'b0}} : count_reg + {{(W-1){1'b0}}, 1'b1};
      tick_out <= wrap;
    end else begin
      count_reg <= {W{1'b0}};
      tick_out <= 1'b0;
    end
  end

endmodule

// ===== hw/cmc_clock_config.v
// Clock mode capture, mode and control registers, APB slave and tick dividers
`timescale 1ns/1ps
`include "cmc_defs.vh"

module cmc_clock_config #(
  parameter ADDR_W = `CMC_ADDR_W
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [2:0] clock_mode_pins_in,
  input wire [2:0] clock_mode_high_bits_in,
  input wire delay_loop_disable_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output wire pready_out,
  output reg [31:0] prdata_out,
  output reg pslverr_out,
  output wire mode_valid_out,
  output wire [3:0] core_pll_prediv_out,
  output wire [3:0] core_pll_multiplier_out,
  output wire [3:0] bus_divider_out,
  output wire [3:0] periph_processor_divider_out,
  output wire [3:0] system_pll_prediv_out,
  output wire [3:0] system_pll_multiplier_out,
  output wire delay_loop_disable_out,
  output wire [3:0] core_divider_out,
  output wire config_unsupported_out,
  output wire baud_generator_tick_out,
  output wire scc_tick_out,
  output reg external_clock_output_out
);

  // ----------------------------------------
  // Capture sequencer states
  // ----------------------------------------
  localparam ST_WAIT = 3'b001;
  localparam ST_LOAD = 3'b010;
  localparam ST_DONE = 3'b100;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [6:0] pin_meta_reg;
  reg [6:0] pin_sync_reg;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_reg <= 7'h00;
      pin_sync_reg <= 7'h00;
    end else begin
      pin_meta_reg <= {delay_loop_disable_in, clock_mode_high_bits_in, clock_mode_pins_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------
  // Mode value and field mapping
  // ----------------------------------------
  wire [5:0] mode_value;
  wire [3:0] cpdf_code;
  wire [3:0] bus_divider_code;
  wire [3:0] ppdf_code;
  wire [3:0] spdf_code;
  wire [3:0] smf_code;
  wire [3:0] core_divider_code;
  wire [31:0] mode_image;

  // Pins form the low half, config-word bits the high half
  assign mode_value = {pin_sync_reg[5:3], pin_sync_reg[2:0]};

  assign cpdf_code = {2'b00, mode_value[1:0]};
  assign bus_divider_code = {2'b00, mode_value[3:2]} + `CMC_BUS_DIVIDER_MIN;
  assign ppdf_code = {3'b000, mode_value[4]};
  assign spdf_code = {3'b000, mode_value[5]};
  assign smf_code = {1'b0, mode_value[2:0]} + `CMC_SMF_MIN;
  assign core_divider_code = {2'b00, mode_value[5:4]};

  assign mode_image = {core_divider_code, 2'b00, pin_sync_reg[6], 1'b0, smf_code, spdf_code,
                       ppdf_code, bus_divider_code, `CMC_CORE_MF_CODE, cpdf_code};

  // ----------------------------------------
  // Capture at power-on reset release
  // ----------------------------------------
  reg [2:0] cap_state_reg;
  reg [2:0] cap_state_next;
  reg [1:0] cap_wait_reg;
  reg [31:0] mode_reg;

  // Waits for the synchronisers to hold real pin levels before loading
  always @* begin
    cap_state_next = cap_state_reg;
    case (cap_state_reg)
      ST_WAIT: begin
        if (cap_wait_reg == `CMC_CAPTURE_WAIT) begin
          cap_state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        cap_state_next = ST_DONE;
      end
      ST_DONE: begin
        cap_state_next = ST_DONE;
      end
      default: begin
        cap_state_next = ST_WAIT;
      end
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_state_reg <= ST_WAIT;
      cap_wait_reg <= 2'h0;
      mode_reg <= 32'h00000000;
    end else begin
      cap_state_reg <= cap_state_next;
      if (cap_state_reg == ST_WAIT) begin
        cap_wait_reg <= cap_wait_reg + 2'h1;
      end
      // Loaded exactly once; nothing else writes it
      if (cap_state_reg == ST_LOAD) begin
        mode_reg <= mode_image;
      end
    end
  end

  assign mode_valid_out = (cap_state_reg == ST_DONE);

  // Fields drive the clock generation controls directly
  assign core_pll_prediv_out = mode_reg[`CMC_MODE_CPDF_LSB+3:`CMC_MODE_CPDF_LSB];
  assign core_pll_multiplier_out = mode_reg[`CMC_MODE_CMF_LSB+3:`CMC_MODE_CMF_LSB];
  assign bus_divider_out = mode_reg[`CMC_MODE_BUS_DIVIDER_LSB+3:`CMC_MODE_BUS_DIVIDER_LSB];
  assign periph_processor_divider_out = mode_reg[`CMC_MODE_PPDF_LSB+3:`CMC_MODE_PPDF_LSB];
  assign system_pll_prediv_out = mode_reg[`CMC_MODE_SPDF_LSB+3:`CMC_MODE_SPDF_LSB];
  assign system_pll_multiplier_out = mode_reg[`CMC_MODE_SMF_LSB+3:`CMC_MODE_SMF_LSB];
  assign delay_loop_disable_out = mode_reg[`CMC_MODE_DELAY_LOOP_DISABLE_BIT];
  assign core_divider_out = mode_reg[`CMC_MODE_CORE_DIVIDER_LSB+3:`CMC_MODE_CORE_DIVIDER_LSB];

  // ----------------------------------------
  // Unsupported code check
  // ----------------------------------------
  // With this pin mapping every code is legal; the flag guards later remaps
  wire cpdf_bad;
  wire cmf_bad;
  wire bus_divider_bad;
  wire ppdf_bad;
  wire spdf_bad;
  wire smf_bad;
  wire core_divider_bad;
  reg unsupported_reg;

  // Each field judged against its own code set
  assign cpdf_bad = (core_pll_prediv_out > `CMC_CPDF_MAX);
  assign cmf_bad = (core_pll_multiplier_out != `CMC_CORE_MF_CODE);
  assign bus_divider_bad = (bus_divider_out < `CMC_BUS_DIVIDER_MIN) ||
    (bus_divider_out > `CMC_BUS_DIVIDER_MAX);
  assign ppdf_bad = (periph_processor_divider_out > `CMC_PPDF_MAX);
  assign spdf_bad = (system_pll_prediv_out > `CMC_SPDF_MAX);
  assign smf_bad = (system_pll_multiplier_out < `CMC_SMF_MIN);
  assign core_divider_bad = (core_divider_out > `CMC_CORE_DIVIDER_MAX);

  // Registered so the flag leaves the block from a flip-flop
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unsupported_reg <= 1'b0;
    end else begin
      // Before capture the zero image is not a mode and is not judged
      unsupported_reg <= mode_valid_out &&
        (cpdf_bad || cmf_bad || bus_divider_bad || ppdf_bad || spdf_bad || smf_bad || core_divider_bad);
    end
  end

  assign config_unsupported_out = unsupported_reg;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  reg clkdis_reg;
  reg [1:0] baud_sel_reg;
  wire setup_phase;
  wire access_phase;
  wire ctrl_hit;
  wire mode_hit;

  assign setup_phase = psel_in && !penable_in;
  assign access_phase = psel_in && penable_in;
  assign ctrl_hit = (paddr_in == `CMC_CTRL_ADDR);
  assign mode_hit = (paddr_in == `CMC_MODE_ADDR);

  // Both fields live in byte lane 3; reserved bits are not stored
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clkdis_reg <= `CMC_CTRL_CLKDIS_RST;
      baud_sel_reg <= `CMC_CTRL_BAUD_RST;
    end else if (access_phase && pwrite_in && ctrl_hit && pstrb_in[3]) begin
      clkdis_reg <= pwdata_in[`CMC_CTRL_CLKDIS_BIT];
      baud_sel_reg <= pwdata_in[`CMC_CTRL_BAUD_MSB:`CMC_CTRL_BAUD_LSB];
    end
  end

  // ----------------------------------------
  // APB read data and error
  // ----------------------------------------
  // Zero wait state; data is prepared in the setup cycle
  assign pready_out = 1'b1;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else if (setup_phase) begin
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
      if (ctrl_hit) begin
        prdata_out[`CMC_CTRL_BAUD_MSB:`CMC_CTRL_BAUD_LSB] <= baud_sel_reg;
        prdata_out[`CMC_CTRL_CLKDIS_BIT] <= clkdis_reg;
      end else if (mode_hit) begin
        // Writes here are silently dropped
        prdata_out <= mode_reg;
      end else begin
        pslverr_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Baud and serial controller tick dividers
  // ----------------------------------------
  reg [7:0] baud_ratio_m1;

  always @* begin
    case (baud_sel_reg)
      2'b00: baud_ratio_m1 = `CMC_BAUD_DIV4_M1;
      2'b01: baud_ratio_m1 = `CMC_BAUD_DIV16_M1;
      2'b10: baud_ratio_m1 = `CMC_BAUD_DIV64_M1;
      default: baud_ratio_m1 = `CMC_BAUD_DIV256_M1;
    endcase
  end

  // Counter keeps running across a ratio change, so no restart or stall
  cmc_clk_div #(
    .W(8)
  ) u_baud_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(mode_valid_out),
    .ratio_m1_in(baud_ratio_m1),
    .tick_out(baud_generator_tick_out)
  );

  cmc_clk_div #(
    .W(8)
  ) u_scc_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(mode_valid_out),
    .ratio_m1_in(`CMC_SCC_DIV_M1),
    .tick_out(scc_tick_out)
  );

  // ----------------------------------------
  // External clock output
  // ----------------------------------------
  // Half-rate square wave; held low while disabled
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      external_clock_output_out <= 1'b0;
    end else if (clkdis_reg || !mode_valid_out) begin
      external_clock_output_out <= 1'b0;
    end else begin
      external_clock_output_out <= !external_clock_output_out;
    end
  end

endmodule

// ===== verification/cmc_clock_config_asserts.sv
// Assertion checker for the clock configuration block
`timescale 1ns/1ps
`include "cmc_defs.vh"
module cmc_clock_config_chk #(
  parameter ADDR_W = `CMC_ADDR_W
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  input wire pslverr_out,
  input wire mode_valid_out,
  input wire [3:0] core_pll_multiplier_out,
  input wire [3:0] bus_divider_out,
  input wire [3:0] core_divider_out,
  input wire config_unsupported_out,
  input wire scc_tick_out,
  input wire external_clock_output_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Shadow of the output disable bit, rebuilt from bus writes
  reg dis_reg;
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      dis_reg <= 1'b0;
    else if (psel_in && penable_in && pwrite_in && pstrb_in[3] && paddr_in == `CMC_CTRL_ADDR)
      dis_reg <= pwdata_in[`CMC_CTRL_CLKDIS_BIT];
  sequence s_off; dis_reg[*3]; endsequence
  sequence s_on; (mode_valid_out && !dis_reg)[*3]; endsequence
  sequence s_setup; psel_in && !penable_in; endsequence
  a_scc_tick_gap: assert property (scc_tick_out |=> (!scc_tick_out)[*3] ##1 scc_tick_out)
    else $error("scc tick spacing wrong");
  a_mode_frozen: assert property (mode_valid_out |=> mode_valid_out && $stable({core_divider_out, bus_divider_out}))
    else $error("captured mode changed");
  a_core_mf_code: assert property (mode_valid_out |-> core_pll_multiplier_out == 4'h5)
    else $error("core multiplier code wrong");
  a_bus_div_range: assert property (mode_valid_out |-> bus_divider_out inside {[4'h1:4'h5]})
    else $error("bus divider code out of range");
  a_core_div_range: assert property (mode_valid_out |-> core_divider_out <= 4'h5)
    else $error("core divider code out of range");
  a_code_support: assert property (!config_unsupported_out)
    else $error("unsupported mode captured");
  a_external_clock_output_off: assert property (s_off |-> !external_clock_output_out)
    else $error("clock output runs while disabled");
  a_external_clock_output_run: assert property (s_on |-> external_clock_output_out != $past(external_clock_output_out))
    else $error("clock output stalled while enabled");
  a_unmapped_err: assert property (s_setup |=> pslverr_out == $past(paddr_in != `CMC_CTRL_ADDR && paddr_in != `CMC_MODE_ADDR))
    else $error("error response wrong");
endmodule
bind cmc_clock_config cmc_clock_config_chk #(.ADDR_W(ADDR_W)) cmc_clock_config_chk_i (.*);

// ===== verification/cmc_board_model.sv
// Board model driving the clock mode straps
`timescale 1ns/1ps
module cmc_board_model (
  input wire [5:0] mode_sel_in,
  input wire dll_off_in,
  output wire [2:0] clock_mode_pins_out,
  output wire [2:0] clock_mode_high_bits_out,
  output wire delay_loop_disable_out
);
  // Static straps; every mode of the mapping stays inside the frequency limits
  assign {clock_mode_high_bits_out, clock_mode_pins_out} = mode_sel_in;
  assign delay_loop_disable_out = dll_off_in;
endmodule

// ===== verification/tb_top.sv
// Testbench for the clock configuration block
`timescale 1ns/1ps
`include "cmc_defs.vh"
module tb_top;
  reg clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [19:0] paddr = 20'h0;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] pstrb = 4'hf;
  reg [5:0] mode_sel = 6'h00;
  reg dll_off = 1'b0;
  reg [31:0] rd;
  reg er;
  wire [2:0] pins, hbits;
  wire dll_pin, pready, perr, mvalid, unsup, btick, stick, extclk, dlld;
  wire [31:0] prdata;
  wire [3:0] cpdf, cmf, bdf, ppdf, spdf, smf, cdf;
  integer n_fail = 0;
  integer samples_checked = 0;
  always #50 clk_in = ~clk_in;
  cmc_board_model cmc_board_model_i (.mode_sel_in(mode_sel), .dll_off_in(dll_off), .clock_mode_pins_out(pins),
    .clock_mode_high_bits_out(hbits), .delay_loop_disable_out(dll_pin));
  cmc_clock_config cmc_clock_config_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .clock_mode_pins_in(pins),
    .clock_mode_high_bits_in(hbits), .delay_loop_disable_in(dll_pin), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(perr), .mode_valid_out(mvalid), .core_pll_prediv_out(cpdf),
    .core_pll_multiplier_out(cmf), .bus_divider_out(bdf), .periph_processor_divider_out(ppdf),
    .system_pll_prediv_out(spdf), .system_pll_multiplier_out(smf), .delay_loop_disable_out(dlld),
    .core_divider_out(cdf), .config_unsupported_out(unsup), .baud_generator_tick_out(btick),
    .scc_tick_out(stick), .external_clock_output_out(extclk));
  task end_of_test;
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function [31:0] em(input [5:0] m, input d);
    em = {2'b0, m[5:4], 2'b0, d, 1'b0, {1'b0, m[2:0]} + 4'h5, 3'b0, m[5], 3'b0, m[4], {2'b0, m[3:2]} + 4'h1,
      4'h5, 2'b0, m[1:0]};
  endfunction
  task apb(input w, input [19:0] a, input [31:0] d);
    integer i;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_in);
      i = i + 1;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task gap(input s, output integer n);
    integer i;
    i = 0;
    n = 0;
    do begin
      @(negedge clk_in);
      i = i + 1;
    end while ((s ? stick : btick) !== 1'b1 && i < 600);
    do begin
      @(negedge clk_in);
      n = n + 1;
    end while ((s ? stick : btick) !== 1'b1 && n < 600);
    if (i >= 600 || n >= 600) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  endtask
  task t_capture(input [5:0] m, input d);
    mode_sel <= m;
    dll_off <= d;
    rst_n_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    apb(1'b0, `CMC_MODE_ADDR, 32'h0);
    chk(rd, em(m, d));
    chk({er, unsup, mvalid, pready}, 4'b0011);
    chk({cdf, 2'b0, dlld, 1'b0, smf, spdf, ppdf, bdf, cmf, cpdf}, em(m, d));
    apb(1'b0, `CMC_CTRL_ADDR, 32'h0);
    chk(rd, 32'h4000_0000);
    // Straps move after capture and a write hits the read-only register
    mode_sel <= ~m;
    dll_off <= ~d;
    apb(1'b1, `CMC_MODE_ADDR, 32'hffff_ffff);
    apb(1'b0, `CMC_MODE_ADDR, 32'h0);
    chk(rd, em(m, d));
    apb(1'b0, 20'h10c84, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
  endtask
  task t_baud;
    integer c, n;
    // Largest ratio first, so each change after the first shrinks a running count
    for (c = 3; c >= 0; c = c - 1) begin
      apb(1'b1, `CMC_CTRL_ADDR, {c[1:0], 30'h0});
      apb(1'b0, `CMC_CTRL_ADDR, 32'h0);
      chk(rd, {c[1:0], 30'h0});
      gap(1'b0, n);
      chk(n, 4 << (2 * c));
      gap(1'b1, n);
      chk(n, 4);
    end
  endtask
  task t_external_clock_output;
    integer i;
    reg p;
    // A write without the top byte lane must leave the control register alone
    @(posedge clk_in);
    pstrb <= 4'h7;
    apb(1'b1, `CMC_CTRL_ADDR, 32'h8800_0000);
    pstrb <= 4'hf;
    apb(1'b0, `CMC_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `CMC_CTRL_ADDR, 32'h4800_0000);
    repeat (3) @(negedge clk_in);
    for (i = 0; i < 6; i = i + 1) begin
      @(negedge clk_in);
      chk(extclk, 1'b0);
    end
    apb(1'b1, `CMC_CTRL_ADDR, 32'h4000_0000);
    repeat (3) @(negedge clk_in);
    p = extclk;
    for (i = 0; i < 6; i = i + 1) begin
      @(negedge clk_in);
      chk(extclk, !p);
      p = extclk;
    end
  endtask
  initial begin
    t_capture(6'h00, 1'b0);
    t_capture(6'h3f, 1'b1);
    t_capture(6'h2a, 1'b0);
    t_baud;
    t_external_clock_output;
    end_of_test;
  end
endmodule
